// file: core/sdcfg_pkg.sv
`default_nettype none
package sdcfg_pkg;
  // Register addresses
  localparam logic [2:0] ADDR_SCALE = 3'h1;
  localparam logic [2:0] ADDR_OFF   = 3'h2;
  localparam logic [2:0] ADDR_BLANK = 3'h3;
  localparam logic [2:0] ADDR_DECAY = 3'h4;
  localparam logic [2:0] ADDR_STALL = 3'h5;
  localparam logic [2:0] ADDR_DRIVE = 3'h6;
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS  = 12;
  // Writable bit masks
  localparam logic [11:0] MASK_SCALE = 12'h7ff;
  localparam logic [11:0] MASK_OFF   = 12'h1ff;
  localparam logic [11:0] MASK_BLANK = 12'h1ff;
  localparam logic [11:0] MASK_DECAY = 12'h7ff;
  localparam logic [11:0] MASK_STALL = 12'hfff;
  localparam logic [11:0] MASK_DRIVE = 12'hfff;
  // Reset values
  localparam logic [11:0] RST_SCALE = 12'h1ff;
  localparam logic [11:0] RST_OFF   = 12'h030;
  localparam logic [11:0] RST_BLANK = 12'h080;
  localparam logic [11:0] RST_DECAY = 12'h110;
  localparam logic [11:0] RST_STALL = 12'h040;
  localparam logic [11:0] RST_DRIVE = 12'h054;
  // Decay mode codes
  typedef enum logic [2:0] {
    SDCFG_DEC_SLOW      = 3'h0,
    SDCFG_DEC_SLOW_MIX  = 3'h1,
    SDCFG_DEC_FAST      = 3'h2,
    SDCFG_DEC_MIX       = 3'h3,
    SDCFG_DEC_SLOW_AUTO = 3'h4,
    SDCFG_DEC_AUTO      = 3'h5
  } sdcfg_decay_t;
  // Timing in ns (window base in us), clock 10 ns
  localparam int CLK_NS        = 10;
  localparam int OFF_STEP_NS   = 500;
  localparam int BLANK_STEP_NS = 20;
  localparam int BLANK_MIN_NS  = 1000;
  localparam int DECAY_STEP_NS = 500;
  localparam int DRV_BASE_NS   = 250;
  localparam int DEG_BASE_NS   = 1000;
  localparam int WIN_BASE_US   = 50;
  localparam int OFF_STEP_CYC   = (OFF_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_MIN_CYC  = (BLANK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DECAY_STEP_CYC = (DECAY_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRV_BASE_CYC   = (DRV_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEG_BASE_CYC   = (DEG_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_BASE_CYC   = (WIN_BASE_US * 1000 + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// file: core/sdcfg_serial.sv
`timescale 1ns/10ps
`default_nettype none
// Serial frame receiver: link clock sampled on mclk
module sdcfg_serial (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        serial_chip_select,
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  input  wire logic [11:0] rd_data,
  output logic             serial_data_out,
  output logic             serial_data_out_en,
  output logic [2:0]       rd_addr,
  output logic             wr_stb,
  output logic [2:0]       wr_addr,
  output logic [11:0]      wr_data
);
  logic [1:0]  cs_s_q;
  logic [2:0]  ck_s_q;
  logic [1:0]  di_s_q;
  logic [4:0]  cnt_q;
  logic [14:0] sh_q;
  logic [11:0] tx_q;
  logic        rnw_q;
  logic        cs;
  logic        rise;
  logic        fall;
  logic [15:0] frame;

  assign cs    = cs_s_q[1];
  assign rise  = ck_s_q[1] & ~ck_s_q[2];
  assign fall  = ~ck_s_q[1] & ck_s_q[2];
  assign frame = {sh_q, di_s_q[1]};

  // Two-stage synchronisers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_s_q <= 2'h0;
      ck_s_q <= 3'h0;
      di_s_q <= 2'h0;
    end else if (clk_en) begin
      cs_s_q <= {cs_s_q[0], serial_chip_select};
      ck_s_q <= {ck_s_q[1:0], serial_clk};
      di_s_q <= {di_s_q[0], serial_data_in};
    end
  end

  // Shift in R/W, address, data while select high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= 5'h0;
      sh_q    <= 15'h0;
      rnw_q   <= 1'b0;
      wr_stb  <= 1'b0;
      wr_addr <= 3'h0;
      wr_data <= 12'h0;
    end else if (clk_en) begin
      wr_stb <= 1'b0;
      if (!cs) begin
        cnt_q <= 5'h0;
      end else if (rise && cnt_q < 5'(sdcfg_pkg::FRAME_BITS)) begin
        sh_q  <= frame[14:0];
        cnt_q <= cnt_q + 5'h1;
        if (cnt_q == 5'h0) begin
          rnw_q <= di_s_q[1];
        end
        if (cnt_q == 5'(sdcfg_pkg::FRAME_BITS - 1) && !rnw_q) begin
          wr_stb  <= 1'b1;
          wr_addr <= frame[14:12];
          wr_data <= frame[11:0];
        end
      end
    end
  end

  assign rd_addr = sh_q[2:0];

  // Read data shifted out on falling edges after address
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_q               <= 12'h0;
      serial_data_out    <= 1'b0;
      serial_data_out_en <= 1'b0;
    end else if (clk_en) begin
      serial_data_out_en <= cs & rnw_q & (cnt_q >= 5'h4);
      if (cs && fall && rnw_q) begin
        if (cnt_q == 5'h4) begin
          tx_q            <= {rd_data[10:0], 1'b0};
          serial_data_out <= rd_data[11];
        end else if (cnt_q > 5'h4) begin
          tx_q            <= {tx_q[10:0], 1'b0};
          serial_data_out <= tx_q[11];
        end
      end
    end
  end
endmodule // sdcfg_serial
`default_nettype wire

// file: core/sdcfg_regs.sv
`timescale 1ns/10ps
`default_nettype none
module sdcfg_regs (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        serial_chip_select,
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_en,
  input  wire logic        stall_step,
  input  wire logic        bemf_low,
  input  wire logic [1:0]  direct_bridge_inputs,
  input  wire logic [1:0]  indexer_outputs,
  input  wire logic        current_rising,
  output logic [1:0]       bridge_drive,
  output logic [7:0]       current_scale,
  output logic [16:0]      bemf_sample_window,
  output logic [16:0]      off_time_cycles,
  output logic [10:0]      blanking_cycles,
  output logic [10:0]      min_on_cycles,
  output logic             adaptive_blanking_en,
  output logic [16:0]      decay_transition_cycles,
  output logic [1:0]       active_decay,
  output logic [7:0]       stall_threshold,
  output logic [2:0]       bemf_div_shift,
  output logic             stall_out_n,
  output logic [1:0]       overcurrent_threshold,
  output logic [9:0]       overcurrent_deglitch,
  output logic [7:0]       low_gate_drive_time,
  output logic [7:0]       high_gate_drive_time,
  output logic [1:0]       low_gate_sink_current,
  output logic [1:0]       high_gate_source_current
);
  logic [11:0] scale_q;
  logic [11:0] off_q;
  logic [11:0] blank_q;
  logic [11:0] decay_q;
  logic [11:0] stall_q;
  logic [11:0] drive_q;
  logic [2:0]  rd_addr;
  logic [11:0] rd_data;
  logic        wr_stb;
  logic [2:0]  wr_addr;
  logic [11:0] wr_data;
  logic [3:0]  low_cnt_q;
  logic [1:0]  sd_s_q;
  logic [1:0]  bl_s_q;
  logic        sd_d_q;
  logic [1:0]  bi_s0_q;
  logic [1:0]  bi_s1_q;

  sdcfg_serial u_serial (
    .mclk               (mclk),
    .nrst               (nrst),
    .clk_en             (clk_en),
    .serial_chip_select (serial_chip_select),
    .serial_clk         (serial_clk),
    .serial_data_in     (serial_data_in),
    .rd_data            (rd_data),
    .serial_data_out    (serial_data_out),
    .serial_data_out_en (serial_data_out_en),
    .rd_addr            (rd_addr),
    .wr_stb             (wr_stb),
    .wr_addr            (wr_addr),
    .wr_data            (wr_data)
  );

  // Two-bit gate timing code to cycles: 250 ns << code
  function automatic logic [7:0] drv_cycles(input logic [1:0] code);
    drv_cycles = 8'(sdcfg_pkg::DRV_BASE_CYC << code);
  endfunction

  // 500 ns step count to cycles for (code + extra)
  function automatic logic [16:0] step500(input logic [7:0] code, input logic [8:0] extra);
    step500 = 17'((9'(code) + extra) * sdcfg_pkg::OFF_STEP_CYC);
  endfunction

  // Register writes; reserved bits masked
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scale_q <= sdcfg_pkg::RST_SCALE;
      off_q   <= sdcfg_pkg::RST_OFF;
      blank_q <= sdcfg_pkg::RST_BLANK;
      decay_q <= sdcfg_pkg::RST_DECAY;
      stall_q <= sdcfg_pkg::RST_STALL;
      drive_q <= sdcfg_pkg::RST_DRIVE;
    end else if (clk_en && wr_stb) begin
      case (wr_addr)
        sdcfg_pkg::ADDR_SCALE: scale_q <= wr_data & sdcfg_pkg::MASK_SCALE;
        sdcfg_pkg::ADDR_OFF:   off_q   <= wr_data & sdcfg_pkg::MASK_OFF;
        sdcfg_pkg::ADDR_BLANK: blank_q <= wr_data & sdcfg_pkg::MASK_BLANK;
        sdcfg_pkg::ADDR_DECAY: decay_q <= wr_data & sdcfg_pkg::MASK_DECAY;
        sdcfg_pkg::ADDR_STALL: stall_q <= wr_data & sdcfg_pkg::MASK_STALL;
        sdcfg_pkg::ADDR_DRIVE: drive_q <= wr_data & sdcfg_pkg::MASK_DRIVE;
        default: begin
        end
      endcase
    end
  end

  // Read mux
  always_comb begin
    case (rd_addr)
      sdcfg_pkg::ADDR_SCALE: rd_data = scale_q;
      sdcfg_pkg::ADDR_OFF:   rd_data = off_q;
      sdcfg_pkg::ADDR_BLANK: rd_data = blank_q;
      sdcfg_pkg::ADDR_DECAY: rd_data = decay_q;
      sdcfg_pkg::ADDR_STALL: rd_data = stall_q;
      sdcfg_pkg::ADDR_DRIVE: rd_data = drive_q;
      default:               rd_data = 12'h000;
    endcase
  end

  // Back-EMF window code to cycles
  function automatic logic [16:0] win_cycles(input logic [2:0] code);
    case (code)
      3'h0:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC);
      3'h1:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 2);
      3'h2:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 4);
      3'h3:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 6);
      3'h4:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 8);
      3'h5:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 12);
      3'h6:    win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 16);
      default: win_cycles = 17'(sdcfg_pkg::WIN_BASE_CYC * 20);
    endcase
  endfunction

  // Blanking code to cycles; low codes all give the 1 us floor
  function automatic logic [10:0] blank_cycles(input logic [7:0] code);
    if (code <= 8'h32) begin
      blank_cycles = 11'(sdcfg_pkg::BLANK_MIN_CYC);
    end else begin
      blank_cycles = 11'((9'(code) + 9'h001) * sdcfg_pkg::BLANK_STEP_CYC);
    end
  endfunction

  // Low back-EMF steps needed before the stall output asserts
  function automatic logic [3:0] stall_need(input logic [1:0] code);
    stall_need = 4'h1 << code;
  endfunction

  // Current scale and back-EMF window
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      current_scale      <= 8'h00;
      bemf_sample_window <= 17'h00000;
    end else if (clk_en) begin
      current_scale      <= scale_q[7:0];
      bemf_sample_window <= win_cycles(scale_q[10:8]);
    end
  end

  // Fixed off time
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      off_time_cycles <= 17'h00000;
    end else if (clk_en) begin
      off_time_cycles <= step500(off_q[7:0], 9'h001);
    end
  end

  // Blanking doubles as minimum on-time, so both use one decode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blanking_cycles      <= 11'h000;
      min_on_cycles        <= 11'h000;
      adaptive_blanking_en <= 1'b0;
    end else if (clk_en) begin
      blanking_cycles      <= blank_cycles(blank_q[7:0]);
      min_on_cycles        <= blank_cycles(blank_q[7:0]);
      adaptive_blanking_en <= blank_q[8];
    end
  end

  // Mixed-decay transition time
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      decay_transition_cycles <= 17'h00000;
    end else if (clk_en) begin
      decay_transition_cycles <= step500(decay_q[7:0], 9'h000);
    end
  end

  // Stall threshold and back-EMF divider
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stall_threshold <= 8'h00;
      bemf_div_shift  <= 3'h0;
    end else if (clk_en) begin
      stall_threshold <= stall_q[7:0];
      bemf_div_shift  <= 3'(5 - stall_q[11:10]);
    end
  end

  // Over-current and gate drive settings
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overcurrent_threshold    <= 2'h0;
      overcurrent_deglitch     <= 10'h000;
      low_gate_drive_time      <= 8'h00;
      high_gate_drive_time     <= 8'h00;
      low_gate_sink_current    <= 2'h0;
      high_gate_source_current <= 2'h0;
    end else if (clk_en) begin
      overcurrent_threshold    <= drive_q[1:0];
      overcurrent_deglitch     <= 10'(sdcfg_pkg::DEG_BASE_CYC << drive_q[3:2]);
      low_gate_drive_time      <= drv_cycles(drive_q[5:4]);
      high_gate_drive_time     <= drv_cycles(drive_q[7:6]);
      low_gate_sink_current    <= drive_q[9:8];
      high_gate_source_current <= drive_q[11:10];
    end
  end

  // Active decay: 0 slow, 1 fast, 2 mixed, 3 auto mixed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active_decay <= 2'h0;
    end else if (clk_en) begin
      case (decay_q[10:8])
        sdcfg_pkg::SDCFG_DEC_SLOW:      active_decay <= 2'h0;
        sdcfg_pkg::SDCFG_DEC_FAST:      active_decay <= 2'h1;
        sdcfg_pkg::SDCFG_DEC_MIX:       active_decay <= 2'h2;
        sdcfg_pkg::SDCFG_DEC_AUTO:      active_decay <= 2'h3;
        sdcfg_pkg::SDCFG_DEC_SLOW_MIX:  active_decay <= (current_rising || off_q[8]) ? 2'h0 : 2'h2;
        sdcfg_pkg::SDCFG_DEC_SLOW_AUTO: active_decay <= (current_rising || off_q[8]) ? 2'h0 : 2'h3;
        default:                        active_decay <= 2'h0;
      endcase
    end
  end

  // Direct bridge pins come from outside the clock domain
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bi_s0_q <= 2'h0;
      bi_s1_q <= 2'h0;
    end else if (clk_en) begin
      bi_s0_q <= direct_bridge_inputs;
      bi_s1_q <= bi_s0_q;
    end
  end

  // Bridge source select
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bridge_drive <= 2'h0;
    end else if (clk_en) begin
      bridge_drive <= off_q[8] ? bi_s1_q : indexer_outputs;
    end
  end

  // Step and back-EMF pins come from outside the clock domain
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sd_s_q <= 2'h0;
      bl_s_q <= 2'h0;
      sd_d_q <= 1'b0;
    end else if (clk_en) begin
      sd_s_q <= {sd_s_q[0], stall_step};
      bl_s_q <= {bl_s_q[0], bemf_low};
      sd_d_q <= sd_s_q[1];
    end
  end

  // Stall counter on consecutive low back-EMF steps
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_q   <= 4'h0;
      stall_out_n <= 1'b1;
    end else if (clk_en) begin
      if (sd_s_q[1] && !sd_d_q) begin
        if (bl_s_q[1]) begin
          if (low_cnt_q < 4'h8) begin
            low_cnt_q <= low_cnt_q + 4'h1;
          end
          if ((low_cnt_q + 4'h1) >= stall_need(stall_q[9:8])) begin
            stall_out_n <= 1'b0;
          end
        end else begin
          low_cnt_q   <= 4'h0;
          stall_out_n <= 1'b1;
        end
      end
    end
  end
endmodule // sdcfg_regs
`default_nettype wire

// file: tb/sdcfg_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Watches decoded settings and the serial read line
module sdcfg_assertions (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        serial_chip_select,
  input wire logic        serial_clk,
  input wire logic        serial_data_out,
  input wire logic        serial_data_out_en,
  input wire logic [16:0] bemf_sample_window,
  input wire logic [16:0] off_time_cycles,
  input wire logic [10:0] blanking_cycles,
  input wire logic [10:0] min_on_cycles,
  input wire logic [2:0]  bemf_div_shift,
  input wire logic [9:0]  overcurrent_deglitch,
  input wire logic [7:0]  low_gate_drive_time
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  min_on_same_a: assert property (min_on_cycles == blanking_cycles)
    else $error("min on time differs from blanking");
  blank_floor_a: assert property ($past(nrst, 2) |-> blanking_cycles inside {[100:512]})
    else $error("blanking out of range");
  off_step_a: assert property ($past(nrst, 2) |->
    off_time_cycles % 50 == 0 && off_time_cycles inside {[50:12800]})
    else $error("off time not a 500 ns step");
  div_range_a: assert property ($past(nrst, 2) |-> bemf_div_shift inside {[2:5]})
    else $error("divider shift out of range");
  deglitch_set_a: assert property ($past(nrst, 2) |->
    overcurrent_deglitch inside {100, 200, 400, 800})
    else $error("deglitch count wrong");
  low_drive_a: assert property ($past(nrst, 2) |->
    low_gate_drive_time inside {25, 50, 100, 200})
    else $error("low drive time wrong");
  window_set_a: assert property ($past(nrst, 2) |-> bemf_sample_window inside
    {5000, 10000, 20000, 30000, 40000, 60000, 80000, 100000})
    else $error("sample window wrong");
  sdo_select_a: assert property ($rose(serial_data_out_en) |-> serial_chip_select)
    else $error("read line driven without select");
  sdo_hold_a: assert property (serial_clk [*6] |-> $stable(serial_data_out))
    else $error("read bit moved while link clock high");
endmodule // sdcfg_assertions
bind sdcfg_regs sdcfg_assertions chk_i (.mclk, .nrst, .serial_chip_select, .serial_clk,
  .serial_data_out, .serial_data_out_en, .bemf_sample_window, .off_time_cycles,
  .blanking_cycles, .min_on_cycles, .bemf_div_shift, .overcurrent_deglitch,
  .low_gate_drive_time);
`default_nettype wire

// file: tb/sdcfg_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host on the serial port; link clock stands low between frames
module sdcfg_host (
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_en,
  output var logic  serial_chip_select,
  output var logic  serial_clk,
  output var logic  serial_data_in
);
  initial begin
    serial_chip_select = 1'b0;
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  // Sends the first n bits of a frame; a short frame drops select early
  task automatic xfer(input logic rw, input logic [2:0] a, input logic [11:0] d,
                      input int n, output logic [11:0] q);
    logic [15:0] f;
    f = {rw, a, d};
    q = 12'h000;
    serial_chip_select = 1'b1;
    #100;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_in = f[i];
      #62.5 serial_clk = 1'b1;
      if (i < 12) q = {q[10:0], serial_data_out_en ? serial_data_out : ~q[0]};
      #62.5 serial_clk = 1'b0;
    end
    #100 serial_chip_select = 1'b0;
    serial_data_in = ~serial_data_in;
    #300;
  endtask
endmodule // sdcfg_host
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk, nrst, clk_en, stall_step, bemf_low, current_rising, stall_out_n;
  logic serial_chip_select, serial_clk, serial_data_in, serial_data_out, serial_data_out_en;
  logic adaptive_blanking_en;
  logic [1:0] direct_bridge_inputs, indexer_outputs, bridge_drive, active_decay;
  logic [1:0] overcurrent_threshold, low_gate_sink_current, high_gate_source_current;
  logic [2:0] bemf_div_shift;
  logic [7:0] current_scale, stall_threshold, low_gate_drive_time, high_gate_drive_time;
  logic [9:0] overcurrent_deglitch;
  logic [10:0] blanking_cycles, min_on_cycles;
  logic [16:0] bemf_sample_window, off_time_cycles, decay_transition_cycles;
  logic [11:0] q;
  int n_fail, n_checks, i;
  int win_us [8] = '{50, 100, 200, 300, 400, 600, 800, 1000};
  logic [1:0] dec_up [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0, 2'h0};
  logic [1:0] dec_dn [8] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0};
  logic [11:0] rst_v [8] = '{12'h0, 12'h1ff, 12'h30, 12'h80, 12'h110, 12'h40, 12'h54, 12'h0};
  logic [11:0] msk_v [8] = '{12'h0, 12'h7ff, 12'h1ff, 12'h1ff, 12'h7ff, 12'hfff, 12'hfff, 12'h0};
  sdcfg_regs uut (.mclk, .nrst, .clk_en, .serial_chip_select, .serial_clk, .serial_data_in,
    .serial_data_out, .serial_data_out_en, .stall_step, .bemf_low, .direct_bridge_inputs,
    .indexer_outputs, .current_rising, .bridge_drive, .current_scale, .bemf_sample_window,
    .off_time_cycles, .blanking_cycles, .min_on_cycles, .adaptive_blanking_en,
    .decay_transition_cycles, .active_decay, .stall_threshold, .bemf_div_shift, .stall_out_n,
    .overcurrent_threshold, .overcurrent_deglitch, .low_gate_drive_time, .high_gate_drive_time,
    .low_gate_sink_current, .high_gate_source_current);
  sdcfg_host host (.serial_data_out, .serial_data_out_en, .serial_chip_select, .serial_clk,
    .serial_data_in);
  always #5 mclk = ~mclk;
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    logic [11:0] r;
    host.xfer(1'b0, a, d, 16, r);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [11:0] e);
    logic [11:0] r;
    host.xfer(1'b1, a, 12'h000, 16, r);
    chk(17'(r), 17'(e));
  endtask
  task automatic step(input logic low);
    @(posedge mclk);
    bemf_low <= low;
    repeat (4) @(posedge mclk);
    stall_step <= 1'b1;
    repeat (6) @(posedge mclk);
    stall_step <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic wait_stall(input logic e);
    for (int k = 0; k < 60 && stall_out_n !== e; k++) @(posedge mclk);
    #1;
    chk(17'(stall_out_n), 17'(e));
    if (stall_out_n !== e) wrap_up();
  endtask
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    stall_step = 1'b0;
    bemf_low = 1'b0;
    current_rising = 1'b1;
    direct_bridge_inputs = 2'h2;
    indexer_outputs = 2'h1;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(17'(current_scale), 17'h000ff);
    chk(bemf_sample_window, 17'd10000);
    chk(off_time_cycles, 17'd2450);
    chk(17'(blanking_cycles), 17'd258);
    chk(17'(adaptive_blanking_en), 17'h0);
    chk(decay_transition_cycles, 17'd800);
    chk(17'(active_decay), 17'h0);
    chk(17'(stall_threshold), 17'h00040);
    chk(17'(stall_out_n), 17'h1);
    chk(17'(bemf_div_shift), 17'h5);
    chk(17'(overcurrent_deglitch), 17'd200);
    chk(17'(high_gate_drive_time), 17'd50);
    chk(17'(bridge_drive), 17'h1);
    for (i = 0; i < 8; i++) rdc(i[2:0], rst_v[i]);
    $display("test defaults done");
    for (i = 0; i < 8; i++) wr(i[2:0], 12'hfff);
    for (i = 0; i < 8; i++) rdc(i[2:0], msk_v[i]);
    chk(off_time_cycles, 17'd12800);
    chk(17'(blanking_cycles), 17'd512);
    chk(17'(adaptive_blanking_en), 17'h1);
    chk(decay_transition_cycles, 17'd12750);
    chk(17'(stall_threshold), 17'h000ff);
    chk(17'(bridge_drive), 17'h2);
    wr(3'h3, 12'h000);
    chk(17'(blanking_cycles), 17'd100);
    wr(3'h3, 12'h033);
    chk(17'(blanking_cycles), 17'd104);
    chk(17'(min_on_cycles), 17'd104);
    $display("test ones done");
    for (i = 0; i < 4; i++) begin
      wr(3'h6, {i[1:0], i[1:0], i[1:0], i[1:0], i[1:0], i[1:0]});
      wr(3'h5, {i[1:0], 2'h0, 8'h40});
      chk(17'(overcurrent_threshold), 17'(i));
      chk(17'(overcurrent_deglitch), 17'(100 << i));
      chk(17'(low_gate_drive_time), 17'(25 << i));
      chk(17'(high_gate_drive_time), 17'(25 << i));
      chk(17'(low_gate_sink_current), 17'(i));
      chk(17'(high_gate_source_current), 17'(i));
      chk(17'(bemf_div_shift), 17'(5 - i));
    end
    for (i = 0; i < 8; i++) begin
      wr(3'h1, {1'b0, i[2:0], 8'h5a});
      chk(bemf_sample_window, 17'(win_us[i] * 100));
    end
    chk(17'(current_scale), 17'h0005a);
    $display("test codes done");
    for (i = 0; i < 32; i++) begin
      wr(3'h2, {3'h0, i[4], 8'h30});
      wr(3'h4, {1'b0, i[2:0], 8'h10});
      @(posedge mclk);
      current_rising <= i[3];
      repeat (4) @(posedge mclk);
      #1;
      chk(17'(active_decay), 17'((i[3] || i[4]) ? dec_up[i % 8] : dec_dn[i % 8]));
    end
    $display("test decay done");
    for (i = 0; i < 4; i++) begin
      wr(3'h5, {2'h0, i[1:0], 8'h40});
      step(1'b0);
      wait_stall(1'b1);
      repeat ((1 << i) - 1) step(1'b1);
      #1;
      chk(17'(stall_out_n), 17'h1);
      step(1'b1);
      wait_stall(1'b0);
    end
    $display("test stall done");
    wr(3'h1, 12'h0ab);
    host.xfer(1'b0, 3'h1, 12'h155, 10, q);
    rdc(3'h1, 12'h0ab);
    chk(17'(current_scale), 17'h000ab);
    @(posedge mclk);
    clk_en <= 1'b0;
    #1;
    wr(3'h1, 12'h012);
    chk(17'(current_scale), 17'h000ab);
    @(posedge mclk);
    clk_en <= 1'b1;
    #1;
    rdc(3'h1, 12'h0ab);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(17'(current_scale), 17'h000ff);
    $display("test frame and reset done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
